/* File: rtl/wfbc_pkg.sv */
/*
  constants, field layouts and types for the waveform burst controller.
  assumes a 40 MHz synthesis clock and a 40-bit phase accumulator.
*/
package wfbc_pkg;
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned ACC_W      = 40;
  typedef logic [ACC_W-1:0] wfbc_acc_t;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_COUNT    = 8'h04;
  localparam logic [7:0] OFS_INTERVAL = 8'h08;
  localparam logic [7:0] OFS_PHASE    = 8'h0C;
  localparam logic [7:0] OFS_TUNE_LO  = 8'h10;
  localparam logic [7:0] OFS_TUNE_HI  = 8'h14;
  localparam logic [7:0] OFS_TRIGGER  = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1C;

  // control word, bit 0 is burst_enable
  typedef struct packed {
    logic [2:0] wave;               // 10:8 selected waveform
    logic       endless_count;      // 7
    logic       angle_unit_select;  // 6  0 degrees, 1 milliradians
    logic       gate_input_polarity;// 5  0 high is true
    logic       input_edge_select;  // 4  0 rising
    logic [1:0] trigger_origin;     // 3:2
    logic       burst_style_select; // 1  0 counted, 1 level-gated
    logic       burst_enable;       // 0
  } wfbc_ctrl_t;
  localparam int unsigned CTRL_W = 11;
  localparam wfbc_ctrl_t CTRL_RST = '0;

  localparam logic [2:0] WAVE_SINE   = 3'h0;
  localparam logic [2:0] WAVE_SQUARE = 3'h1;
  localparam logic [2:0] WAVE_NOISE  = 3'h5;
  localparam logic [2:0] WAVE_DC     = 3'h6;
  localparam logic [1:0] ORIGIN_INT  = 2'h0;
  localparam logic [1:0] ORIGIN_EXT  = 2'h1;
  localparam logic [1:0] ORIGIN_SW   = 2'h2;

  // status bits
  localparam int unsigned SB_ACTIVE   = 0;
  localparam int unsigned SB_STYLE    = 1;
  localparam int unsigned SB_CONFLICT = 2;
  localparam int unsigned SB_RANGE    = 3;
  localparam int unsigned SB_REJECT   = 4;

  localparam logic [15:0] COUNT_MIN  = 16'h0001;
  localparam logic [15:0] COUNT_MAX  = 16'hC350;   // 50000
  localparam logic [15:0] COUNT_DEF  = 16'h0001;
  localparam logic [31:0] ENDLESS_CODE = 32'h7E94F56D; // 9.9E+37 float

  localparam logic [28:0] INTERVAL_MIN_US = 29'd1;
  localparam logic [28:0] INTERVAL_MAX_US = 29'd500_000_000;
  localparam logic [34:0] INTERVAL_MAX_CLK =
    35'(64'(INTERVAL_MAX_US) * 64'(CLK_PER_US));
  localparam int unsigned GUARD_NS  = 200;
  localparam logic [3:0]  GUARD_CLK =
    4'((GUARD_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

  localparam logic signed [31:0] PHASE_DEG_MAX  = 32'sd360;
  localparam logic signed [31:0] PHASE_MRAD_MAX = 32'sd6283;
  localparam logic [31:0] PHASE_PER_DEG  = 32'd3054198967;
  localparam logic [31:0] PHASE_PER_MRAD = 32'd174992360;

  // tuning words: 2.001 mHz rounded up, 6 MHz rounded down
  localparam wfbc_acc_t TW_MIN  = 40'd56;
  localparam wfbc_acc_t TW_6MHZ = 40'd164926744166;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_DRAIN = 3'b100
  } wfbc_state_t;
endpackage

/* File: rtl/wfbc_burst.sv */
/*
  waveform burst controller: burst sequencing, trigger selection, interval
  timer, limit checks and an AXI4-Lite register slave.
  assumes TRIG_IN and MANUAL_TRIG are synchronous to CLK, MANUAL_TRIG is a
  one-cycle pulse, and the synthesis datapath follows WAVE_PHASE.
*/
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
// Summary of operation
// - counted style emits exactly the set cycles per trigger, then halts
// - gated style runs while gate true, finishes cycle, rests at start phase
// - noise in gated style stops at once when the gate goes false
// - gated style ignores count, interval, origin; manual trigger dropped
// - one style at a time, counted by default, style readable
// - count 1 to 50000, default 1, endless setting runs continuously
// - count readback gives the count or the endless code
// - internal origin: count below max interval times frequency, else fix
// - sine and square above 6 MHz only with endless count
// - count written in gated style is kept for later counted use
// - internal bursts start-to-start interval 1 us to 500 s, 10 ms default
// - interval used only with internal origin in counted style
// - interval above burst length plus 200 ns, else raise and flag; here only flagged, written value kept
// - start phase within plus or minus 360 degrees or radian equivalent
// - frequencies below 2.001 mHz refused for internal bursts
// - noise only in gated style, dc never in a burst
// - counted bursts start on timer, manual key, pin edge or software
// - gate polarity selectable
// - enabling bursts switches off sweep and modulation
// - pin edges during a burst are ignored
// - pin edge selectable rising or falling, rising default
// - zero phase is the positive crossing or first stored point
`timescale 1ns/1ps
module wfbc_burst #(
  parameter logic [28:0] INTERVAL_DEF_US = 29'd10_000
) (
  input  wire logic                 CLK,
  input  wire logic                 RESET_N,
  input  wire logic [7:0]           S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [7:0]           S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY,
  input  wire logic                 TRIG_IN,
  input  wire logic                 MANUAL_TRIG,
  output logic                      BURST_ACTIVE,
  output wfbc_pkg::wfbc_acc_t       WAVE_PHASE,
  output logic                      SWEEP_MOD_OFF
);
  import wfbc_pkg::*;

  wfbc_ctrl_t  ctrl_reg;
  logic [15:0] count_reg;
  logic [28:0] interval_reg;
  logic [31:0] phase_raw_reg;
  wfbc_acc_t   start_reg;
  wfbc_acc_t   tw_reg;
  wfbc_state_t st_reg, st_next;
  wfbc_acc_t   rel_reg, phase_out_reg;
  logic [15:0] cyc_reg;
  logic [34:0] tmr_reg;
  logic [3:0]  guard_reg;
  logic        trig_s1_reg, trig_s2_reg, trig_s3_reg;
  logic        conflict_reg, range_reg, reject_reg, kill_reg;
  logic        aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [7:0]  waddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0]  wstrb_reg;
  logic [1:0]  bresp_reg, rresp_reg;

  // register readback, shared by reads and by strobe merging on writes
  function automatic logic [31:0] rd_val(input logic [7:0] a);
    rd_val = 32'h0000_0000;
    unique case (a)
      OFS_CTRL:     rd_val = {21'h0, ctrl_reg};
      OFS_COUNT:    rd_val = ctrl_reg.endless_count ? ENDLESS_CODE :
                             {16'h0, count_reg};
      OFS_INTERVAL: rd_val = {3'h0, interval_reg};
      OFS_PHASE:    rd_val = phase_raw_reg;
      OFS_TUNE_LO:  rd_val = tw_reg[31:0];
      OFS_TUNE_HI:  rd_val = {24'h0, tw_reg[39:32]};
      OFS_STATUS:   rd_val = {27'h0, reject_reg, range_reg, conflict_reg,
                              ctrl_reg.burst_style_select,
                              st_reg != ST_IDLE};
      default:      rd_val = 32'h0000_0000;
    endcase
  endfunction

  // address decode; unmapped offsets answer SLVERR
  wire logic a_ok_w = (waddr_reg[1:0] == 2'b00) && (waddr_reg <= OFS_STATUS);
  wire logic a_ok_r = (S_AXI_ARADDR[1:0] == 2'b00) &&
                      (S_AXI_ARADDR <= OFS_STATUS);
  wire logic do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire logic ar_take  = S_AXI_ARVALID && !rvalid_reg;
  wire logic [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                             {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire logic [31:0] wd = (wdata_reg & wmask) | (rd_val(waddr_reg) & ~wmask);
  wire logic [31:0] wd_raw = wdata_reg & wmask;
  wire logic wr_ctrl  = do_write && a_ok_w && waddr_reg == OFS_CTRL;
  wire logic wr_count = do_write && a_ok_w && waddr_reg == OFS_COUNT;
  wire logic wr_ivl   = do_write && a_ok_w && waddr_reg == OFS_INTERVAL;
  wire logic wr_phase = do_write && a_ok_w && waddr_reg == OFS_PHASE;
  wire logic wr_tlo   = do_write && a_ok_w && waddr_reg == OFS_TUNE_LO;
  wire logic wr_thi   = do_write && a_ok_w && waddr_reg == OFS_TUNE_HI;
  wire logic sw_trig  = do_write && a_ok_w && waddr_reg == OFS_TRIGGER &&
                        wd_raw[0];
  wire logic wr_stat  = do_write && a_ok_w && waddr_reg == OFS_STATUS;

  assign S_AXI_AWREADY = !aw_hold_reg && !bvalid_reg;
  assign S_AXI_WREADY  = !w_hold_reg && !bvalid_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign S_AXI_RDATA   = rdata_reg;

  // AXI channel holding: address and data may arrive in either order
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      waddr_reg   <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_reg <= 1'b1;
        waddr_reg   <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA;
        wstrb_reg  <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= a_ok_w ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= a_ok_r ? rd_val(S_AXI_ARADDR) : 32'h0000_0000;
        rresp_reg  <= a_ok_r ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // write checks, done on the value being written
  wire wfbc_ctrl_t ctrl_new = wfbc_ctrl_t'(wd[CTRL_W-1:0]);
  wire logic ctrl_bad = ctrl_new.burst_enable &&
    (ctrl_new.wave == WAVE_DC ||
     (ctrl_new.wave == WAVE_NOISE && !ctrl_new.burst_style_select));
  wire logic [15:0] cnt_new = (wd[31:16] != 16'h0 || wd[15:0] > COUNT_MAX) ?
    COUNT_MAX : (wd[15:0] < COUNT_MIN ? COUNT_MIN : wd[15:0]);
  wire logic cnt_oor = wd[31:16] != 16'h0 || wd[15:0] > COUNT_MAX ||
                       wd[15:0] < COUNT_MIN;
  wire logic [75:0] max_cycles = 76'(INTERVAL_MAX_CLK) * 76'(tw_reg);
  wire logic cnt_conflict = ctrl_reg.trigger_origin == ORIGIN_INT &&
    !ctrl_reg.endless_count &&
    76'({cnt_new, 40'h0}) >= max_cycles;
  wire logic [28:0] ivl_new = (wd[31:29] != 3'h0 ||
    wd[28:0] > INTERVAL_MAX_US) ? INTERVAL_MAX_US :
    (wd[28:0] < INTERVAL_MIN_US ? INTERVAL_MIN_US : wd[28:0]);
  wire logic [75:0] ivl_span = 76'(35'(ivl_new) * 35'(CLK_PER_US)) *
                               76'(tw_reg);
  wire logic [75:0] need_span = 76'({count_reg, 40'h0}) +
                                76'(GUARD_CLK) * 76'(tw_reg);
  wire logic ivl_short = !ctrl_reg.endless_count && ivl_span <= need_span;
  wire logic ivl_oor = ivl_new != wd[28:0] || wd[31:29] != 3'h0;
  wire logic signed [31:0] ph_lim = ctrl_reg.angle_unit_select ?
                                    PHASE_MRAD_MAX : PHASE_DEG_MAX;
  wire logic signed [31:0] ph_in = $signed(wd);
  wire logic signed [31:0] ph_new = ph_in > ph_lim ? ph_lim :
                                    (ph_in < -ph_lim ? -ph_lim : ph_in);
  wire logic [63:0] ph_word = 64'($signed(ph_new)) * 64'(
    ctrl_reg.angle_unit_select ? PHASE_PER_MRAD : PHASE_PER_DEG);
  wire wfbc_acc_t tw_new = wr_thi ? {wd[7:0], tw_reg[31:0]} :
                                    {tw_reg[39:32], wd};
  wire logic internal_use = ctrl_reg.burst_enable &&
    !ctrl_reg.burst_style_select && ctrl_reg.trigger_origin == ORIGIN_INT;
  wire logic tw_bad = (internal_use && tw_new < TW_MIN) ||
    ((ctrl_reg.wave == WAVE_SINE || ctrl_reg.wave == WAVE_SQUARE) &&
     !ctrl_reg.endless_count && tw_new > TW_6MHZ);

  // settings registers; every field returns to its default at reset
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg      <= CTRL_RST;
      count_reg     <= COUNT_DEF;
      interval_reg  <= INTERVAL_DEF_US;
      phase_raw_reg <= 32'h0000_0000;
      start_reg     <= '0;
      tw_reg        <= TW_MIN;
    end else begin
      if (wr_ctrl && !ctrl_bad)
        ctrl_reg <= ctrl_new;
      if (wr_count)
        count_reg <= cnt_new;
      if (wr_count && cnt_conflict)
        interval_reg <= INTERVAL_MAX_US;
      else if (wr_ivl)
        interval_reg <= ivl_new;
      if (wr_phase) begin
        phase_raw_reg <= ph_new;
        start_reg     <= ph_word[ACC_W-1:0];
      end
      if ((wr_tlo || wr_thi) && !tw_bad)
        tw_reg <= tw_new;
    end
  end

  // sticky error flags; a new error wins over a write-one clear
  wire logic set_conflict = wr_count && cnt_conflict;
  wire logic set_range = (wr_ivl && (ivl_short || ivl_oor)) ||
                         (wr_count && cnt_oor) ||
                         (wr_phase && ph_new != ph_in);
  wire logic set_reject = (wr_ctrl && ctrl_bad) ||
                          ((wr_tlo || wr_thi) && tw_bad);
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      conflict_reg <= 1'b0;
      range_reg    <= 1'b0;
      reject_reg   <= 1'b0;
    end else begin
      conflict_reg <= set_conflict ||
                      (conflict_reg && !(wr_stat && wd_raw[SB_CONFLICT]));
      range_reg    <= set_range ||
                      (range_reg && !(wr_stat && wd_raw[SB_RANGE]));
      reject_reg   <= set_reject ||
                      (reject_reg && !(wr_stat && wd_raw[SB_REJECT]));
    end
  end

  // pin synchroniser; only the second and third stages feed logic
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
    end else begin
      trig_s1_reg <= TRIG_IN;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end

  // trigger sources and gate level
  wire logic gate_true = trig_s2_reg ^ ctrl_reg.gate_input_polarity;
  wire logic pin_edge = ctrl_reg.input_edge_select ?
                        (trig_s3_reg && !trig_s2_reg) :
                        (!trig_s3_reg && trig_s2_reg);
  wire logic [34:0] ivl_clk = 35'(interval_reg) * 35'(CLK_PER_US);
  wire logic timer_due = tmr_reg >= ivl_clk - 35'd1 &&
                         guard_reg == GUARD_CLK;
  wire logic counted = !ctrl_reg.burst_style_select;
  wire logic trig_any = MANUAL_TRIG ||
    (ctrl_reg.trigger_origin == ORIGIN_INT && timer_due) ||
    (ctrl_reg.trigger_origin == ORIGIN_EXT && pin_edge) ||
    (ctrl_reg.trigger_origin == ORIGIN_SW && sw_trig);
  wire logic start = ctrl_reg.burst_enable && st_reg == ST_IDLE &&
    (counted ? trig_any : gate_true);
  wire logic [ACC_W:0] rel_sum = {1'b0, rel_reg} + {1'b0, tw_reg};
  wire logic wrap = rel_sum[ACC_W];
  wire logic last_cycle = !ctrl_reg.endless_count &&
                          cyc_reg + 16'd1 == count_reg;
  wire logic is_noise = ctrl_reg.wave == WAVE_NOISE;

  // burst sequencing
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ST_IDLE: if (start) st_next = ST_RUN;
      ST_RUN: begin
        if (!ctrl_reg.burst_enable)
          st_next = ST_IDLE;
        else if (counted && wrap && last_cycle)
          st_next = ST_IDLE;
        else if (!counted && !gate_true)
          st_next = is_noise ? ST_IDLE :
                    (wrap ? ST_IDLE : ST_DRAIN);
      end
      ST_DRAIN: if (wrap || !ctrl_reg.burst_enable) st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
  end

  // accumulator runs relative to the start phase so idle rests there
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg        <= ST_IDLE;
      rel_reg       <= '0;
      phase_out_reg <= '0;
      cyc_reg       <= 16'h0000;
    end else begin
      st_reg        <= st_next;
      rel_reg       <= (st_next == ST_IDLE || st_reg == ST_IDLE) ? '0 :
                       rel_sum[ACC_W-1:0];
      phase_out_reg <= rel_reg + start_reg;
      if (start)
        cyc_reg <= 16'h0000;
      else if (st_reg == ST_RUN && wrap)
        cyc_reg <= cyc_reg + 16'd1;
    end
  end

  // start-to-start interval timer; saturates so enabling fires at once
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tmr_reg   <= '1;
      guard_reg <= GUARD_CLK;
      kill_reg  <= 1'b0;
    end else begin
      if (!ctrl_reg.burst_enable)
        tmr_reg <= '1;
      else if (start)
        tmr_reg <= 35'd0;
      else if (tmr_reg != '1)
        tmr_reg <= tmr_reg + 35'd1;
      if (st_reg != ST_IDLE)
        guard_reg <= 4'h0;
      else if (guard_reg != GUARD_CLK)
        guard_reg <= guard_reg + 4'h1;
      kill_reg <= wr_ctrl && !ctrl_bad && ctrl_new.burst_enable &&
                  !ctrl_reg.burst_enable;
    end
  end

  assign BURST_ACTIVE  = st_reg != ST_IDLE;
  assign WAVE_PHASE    = phase_out_reg;
  assign SWEEP_MOD_OFF = kill_reg;

  // checks
  a_count_stop: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_reg == ST_RUN && counted && ctrl_reg.burst_enable && wrap &&
    last_cycle |=> st_reg == ST_IDLE)
    else $error("burst did not halt after last cycle");
  a_gate_drain: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_reg == ST_RUN && !counted && ctrl_reg.burst_enable && !gate_true &&
    !is_noise && !wrap |=> st_reg == ST_DRAIN)
    else $error("gated run did not finish its cycle");
  a_noise_halt: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_reg == ST_RUN && !counted && is_noise && !gate_true
    |=> st_reg == ST_IDLE)
    else $error("noise did not stop at once");
  a_gate_ignores: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_reg == ST_IDLE && !counted && !gate_true |=> st_reg == ST_IDLE)
    else $error("gated style started without gate");
  a_idle_rest: assert property (@(posedge CLK) disable iff (!RESET_N)
    $fell(BURST_ACTIVE) ##1 $stable(start_reg)
    |-> WAVE_PHASE == start_reg)
    else $error("idle output not at start phase");
  a_count_bounds: assert property (@(posedge CLK) disable iff (!RESET_N)
    count_reg >= COUNT_MIN && count_reg <= COUNT_MAX)
    else $error("count out of range");
  a_ivl_bounds: assert property (@(posedge CLK) disable iff (!RESET_N)
    interval_reg >= INTERVAL_MIN_US && interval_reg <= INTERVAL_MAX_US)
    else $error("interval out of range");
  a_no_retrigger: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_reg == ST_RUN && !wrap |=> $stable(cyc_reg))
    else $error("cycle count disturbed during burst");
  a_enable_kill: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(ctrl_reg.burst_enable) |-> SWEEP_MOD_OFF)
    else $error("sweep and modulation not switched off");
  a_no_dc: assert property (@(posedge CLK) disable iff (!RESET_N)
    ctrl_reg.burst_enable |-> ctrl_reg.wave != WAVE_DC)
    else $error("dc waveform in burst");
  c_counted: cover property (@(posedge CLK) disable iff (!RESET_N)
    st_reg == ST_RUN && counted ##1 st_reg == ST_IDLE);
  c_gate_drain: cover property (@(posedge CLK) disable iff (!RESET_N)
    st_reg == ST_DRAIN ##1 st_reg == ST_IDLE);
  c_internal: cover property (@(posedge CLK) disable iff (!RESET_N)
    start && ctrl_reg.trigger_origin == ORIGIN_INT && tmr_reg != '1);
endmodule

/* File: tb/wfbc_trig_src.sv */
/*
  model of the external trigger and gate source on the trigger pin.
  assumes the bench sets level_req; the pin moves just after a clock edge.
*/
`timescale 1ns/1ps
module wfbc_trig_src (
  input  wire logic CLK,
  input  wire logic level_req,
  output logic      TRIG_IN
);
  // push-pull pin, so it shows the requested level from the next clock edge, never floats
  always @(posedge CLK) begin
    TRIG_IN <= level_req;
  end
endmodule

/* File: tb/testbench.sv */
/*
  bench for the burst controller: register tasks over AXI4-Lite and burst
  scenarios. assumes the controller and the trigger source model.
*/
`timescale 1ns/1ps
module testbench;
  import wfbc_pkg::*;
  logic        clk, reset_n, awv, wv, bry, arv, rry, manual, gate;
  logic        awr, wr_rdy, bv, arr, rv, trig, active, smoff;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  wfbc_acc_t   phase;
  int          n_errors = 0, n_checks = 0, cnt = 0, smo = 0;
  int          tck = 0, t0 = 0;

  wfbc_burst u_dut (.CLK(clk), .RESET_N(reset_n), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .TRIG_IN(trig), .MANUAL_TRIG(manual),
    .BURST_ACTIVE(active), .WAVE_PHASE(phase), .SWEEP_MOD_OFF(smoff));
  wfbc_trig_src u_src (.CLK(clk), .level_req(gate), .TRIG_IN(trig));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // burst length, sweep-off pulses and a free clock count, between edges
  always @(negedge clk) begin
    if (active === 1'b1) cnt++;
    if (smoff === 1'b1) smo++;
    tck++;
  end
  // readies are sampled mid-cycle so the handshake edge is never raced
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(negedge clk);
      ha = awr;
      hw = wr_rdy;
      hb = bv;
      @(posedge clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end while (!hb);
    bry <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [39:0] e);
    logic h, hb;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(negedge clk);
      h = arr;
      hb = rv;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (h) arv <= 1'b0;
    end while (!hb);
    rry <= 1'b0;
    if (nm != "") chk(nm, rd, e);
  endtask
  task automatic chk(input string nm, input logic [39:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // wait until the burst has ended, bounded so a stuck burst cannot hang
  task automatic settle();
    int t;
    t = 0;
    repeat (6) @(negedge clk);
    while (active !== 1'b0 && t < 4000) begin
      @(negedge clk);
      t++;
    end
    // one more edge: the output phase lags the state by a cycle
    @(negedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #500us;
    n_errors++;
    complete_run();
  end
  initial begin
    {reset_n, awv, wv, bry, arv, rry, manual, gate} = '0;
    {awa, ara, wd} = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rchk("ctrl", OFS_CTRL, 40'h0);
    rchk("count", OFS_COUNT, 40'h1);
    rchk("interval", OFS_INTERVAL, 40'h2710);
    rchk("phase", OFS_PHASE, 40'h0);
    rchk("", 8'h20, 40'h0);
    chk("unmapped resp", rs, RESP_SLVERR);
    wr(OFS_COUNT, 32'd60000);
    rchk("count max", OFS_COUNT, 40'hC350);
    rchk("conflict ivl", OFS_INTERVAL, 40'h1DCD6500);
    wr(OFS_COUNT, 32'h0);
    rchk("count min", OFS_COUNT, 40'h1);
    wr(OFS_CTRL, 32'h80);
    rchk("endless", OFS_COUNT, ENDLESS_CODE);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_COUNT, 32'h3);
    wr(OFS_CTRL, 32'h0);
    rchk("kept count", OFS_COUNT, 40'h3);
    $display("test settings done");
    wr(OFS_TUNE_HI, 32'h30);
    rchk("6 MHz limit", OFS_TUNE_HI, 40'h0);
    // 2^36 per clock gives 16 clocks a cycle, 48 for three cycles
    wr(OFS_TUNE_HI, 32'h10);
    wr(OFS_TUNE_LO, 32'h0);
    wr(OFS_CTRL, 32'h9);
    chk("sweep off", smo, 40'h1);
    for (int k = 0; k < 2; k++) begin
      cnt = 0;
      if (k == 0) wr(OFS_TRIGGER, 32'h1);
      else begin
        @(posedge clk);
        manual <= 1'b1;
        @(posedge clk);
        manual <= 1'b0;
      end
      settle();
      chk("burst cycles", cnt, 40'd48);
    end
    // internal origin with a 2 us interval: starts 80 clocks apart
    wr(OFS_INTERVAL, 32'h2);
    wr(OFS_CTRL, 32'h1);
    @(posedge active);
    t0 = tck;
    @(posedge active);
    chk("interval clocks", tck - t0, 40'd80);
    wr(OFS_CTRL, 32'h9);
    settle();
    $display("test counted done");
    // falling edge selected: the rise must not start, the late fall is lost
    wr(OFS_CTRL, 32'h15);
    cnt = 0;
    gate <= 1'b1;
    repeat (10) @(posedge clk);
    gate <= 1'b0;
    repeat (20) @(posedge clk);
    gate <= 1'b1;
    @(posedge clk);
    gate <= 1'b0;
    settle();
    chk("ext burst cycles", cnt, 40'd48);
    $display("test external done");
    wr(OFS_CTRL, 32'h3);
    gate <= 1'b1;
    repeat (80) @(negedge clk);
    chk("gated run", active, 40'h1);
    rchk("status", OFS_STATUS, 40'h1F);
    chk("style", rd[SB_STYLE], 40'h1);
    gate <= 1'b0;
    settle();
    chk("rest phase", phase, 40'h0);
    wr(OFS_CTRL, 32'h23);
    repeat (10) @(negedge clk);
    chk("low true gate", active, 40'h1);
    wr(OFS_CTRL, 32'h523);
    gate <= 1'b1;
    repeat (6) @(negedge clk);
    chk("noise stop", active, 40'h0);
    $display("test gated done");
    wr(OFS_CTRL, 32'h601);
    rchk("dc refused", OFS_CTRL, 40'h523);
    wr(OFS_PHASE, 32'h190);
    rchk("phase clamp", OFS_PHASE, 40'h168);
    // reset in mid-run while a gated noise burst is under way
    gate <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    chk("reset idle", active, 40'h0);
    rchk("reset ctrl", OFS_CTRL, 40'h0);
    $display("test limits done");
    complete_run();
  end
endmodule
